// ==== design/nber_regs.svh ====
// Behaviour
// - Nine storage bits, one per data input, each with its own output.
// - One clock and one output-drive control shared by all nine bits.
// - Bits capture their data only on a rising edge of the device clock.
// - Drive control low: stored nine-bit value appears on the outputs.
// - Drive control high: all nine outputs are high impedance.
// - Drive control never touches storage; load, hold, clear keep working.
// - Clear low forces every bit to zero; enabled outputs then read low.
// - New data is accepted only while clear is held high.
// - Load gate low, clear high: rising edge moves inputs into storage.
// - Load gate high, clear high: stored value and outputs stay unchanged.
`ifndef NBER_REGS_SVH
`define NBER_REGS_SVH

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define NBER_WIDTH 9
`define NBER_SYNC_DEPTH 3
`define NBER_PIN_COUNT 12
`define NBER_PIN_DATA_LSB 0
`define NBER_PIN_LOAD 9
`define NBER_PIN_OE 10
`define NBER_PIN_CLK 11
`define NBER_STORE_RST 9'h000
`define NBER_OE_N_RST 9'h1FF
`define NBER_PINS_RST 12'hE00

`endif

// ==== design/nber_pkg.sv ====
// ---------------------------------------------------------------
// Types shared by the register block
// ---------------------------------------------------------------
package nber_pkg;

    // Gray sequence clear -> hold -> load -> hold
    typedef enum logic [1:0] {
        NBER_CLEAR = 2'h0,
        NBER_HOLD = 2'h1,
        NBER_LOAD = 2'h3
    } nber_func_type;

endpackage

// ==== design/nber_pin_if.sv ====
`timescale 1ns/1ps
`include "nber_regs.svh"

// ---------------------------------------------------------------
// Cleaned pin levels passed from the synchroniser to the storage
// ---------------------------------------------------------------
interface nber_pin_if;
    logic [`NBER_WIDTH-1:0] data;
    logic load_n;
    logic oe_n;
    logic rise;
    logic wipe_ok;

    modport src (output data, output load_n, output oe_n, output rise,
                 output wipe_ok);
    modport dst (input data, input load_n, input oe_n, input rise,
                 input wipe_ok);
endinterface

// ==== design/nber_pin_sync.sv ====
`timescale 1ns/1ps
`include "nber_regs.svh"

module nber_pin_sync
    import nber_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic edge_clock_i,
    input wire logic wipe_n_i,
    input wire logic load_n_i,
    input wire logic oe_n_i,
    input wire logic [`NBER_WIDTH-1:0] data_i,
    nber_pin_if.src pins
);

    // ---------------------------------------------------------------
    // Three-stage chains for the level pins
    // ---------------------------------------------------------------
    logic [`NBER_PIN_COUNT-1:0] raw;
    logic [`NBER_PIN_COUNT-1:0] s1_r, s2_r, s3_r;
    logic [`NBER_PIN_COUNT-1:0] agreed_r, agreed_nxt;
    logic rise_r, rise_nxt;
    logic clear_rst_n;
    logic [`NBER_SYNC_DEPTH-1:0] wipe_r, wipe_nxt;

    assign raw = {edge_clock_i, oe_n_i, load_n_i, data_i};
    assign clear_rst_n = nrst_i & wipe_n_i;

    // Accept a new level only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < `NBER_PIN_COUNT; gi++) begin : g_pin
            always_comb begin
                agreed_nxt[gi] = agreed_r[gi];
                if (s2_r[gi] == s3_r[gi]) begin
                    agreed_nxt[gi] = s3_r[gi];
                end
            end
        end
    endgenerate

    // One pulse per accepted low-to-high clock level
    always_comb begin
        rise_nxt = agreed_nxt[`NBER_PIN_CLK] & ~agreed_r[`NBER_PIN_CLK];
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_r <= `NBER_PINS_RST;
            s2_r <= `NBER_PINS_RST;
            s3_r <= `NBER_PINS_RST;
            agreed_r <= `NBER_PINS_RST;
            rise_r <= 1'b0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            agreed_r <= agreed_nxt;
            rise_r <= rise_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Clear: asserts at once, releases through three stages
    // ---------------------------------------------------------------
    // Async assert keeps the clear clockless; sync release avoids a
    // half-released register on a load edge near the release.
    always_comb begin
        wipe_nxt = {wipe_r[`NBER_SYNC_DEPTH-2:0], 1'b1};
    end

    always_ff @(posedge clk_i or negedge clear_rst_n) begin
        if (!clear_rst_n) begin
            wipe_r <= 3'h0;
        end else begin
            wipe_r <= wipe_nxt;
        end
    end

    assign pins.data = agreed_r[`NBER_WIDTH-1:0];
    assign pins.load_n = agreed_r[`NBER_PIN_LOAD];
    assign pins.oe_n = agreed_r[`NBER_PIN_OE];
    assign pins.rise = rise_r;
    assign pins.wipe_ok = wipe_r[2] & wipe_r[1];

endmodule

// ==== design/nber_top.sv ====
`timescale 1ns/1ps
`include "nber_regs.svh"

module nber_top
    import nber_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic edge_clock_i,
    input wire logic wipe_n_i,
    input wire logic load_n_i,
    input wire logic oe_n_i,
    input wire logic [`NBER_WIDTH-1:0] data_i,
    output logic [`NBER_WIDTH-1:0] data_o,
    output logic [`NBER_WIDTH-1:0] data_oe_n_o,
    output logic [1:0] func_o
);

    // ---------------------------------------------------------------
    // Pin cleaning
    // ---------------------------------------------------------------
    nber_pin_if pins ();

    nber_pin_sync u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .edge_clock_i(edge_clock_i),
        .wipe_n_i(wipe_n_i),
        .load_n_i(load_n_i),
        .oe_n_i(oe_n_i),
        .data_i(data_i),
        .pins(pins)
    );

    // ---------------------------------------------------------------
    // Storage bits
    // ---------------------------------------------------------------
    logic clear_rst_n;
    logic [`NBER_WIDTH-1:0] store_r, store_nxt;
    logic [`NBER_WIDTH-1:0] oe_n_r, oe_n_nxt;
    nber_func_type func_r, func_nxt;
    logic take;

    // Clear pin resets storage directly, no clock edge needed
    assign clear_rst_n = nrst_i & wipe_n_i;

    // Load only on an accepted rising edge with gate low, clear released
    assign take = pins.rise & ~pins.load_n & pins.wipe_ok;

    genvar gi;
    generate
        for (gi = 0; gi < `NBER_WIDTH; gi++) begin : g_bit
            // Each bit follows only its own input line
            always_comb begin
                store_nxt[gi] = store_r[gi];
                if (take) begin
                    store_nxt[gi] = pins.data[gi];
                end
            end

            // Shared drive control, one enable per output line
            always_comb begin
                oe_n_nxt[gi] = pins.oe_n;
            end
        end
    endgenerate

    // Storage is cleared by the pin; the drive enable is not
    always_ff @(posedge clk_i or negedge clear_rst_n) begin
        if (!clear_rst_n) begin
            store_r <= `NBER_STORE_RST;
        end else begin
            store_r <= store_nxt;
        end
    end

    // Drive enable lives apart so clear and drive never interact
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oe_n_r <= `NBER_OE_N_RST;
        end else begin
            oe_n_r <= oe_n_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Function indicator
    // ---------------------------------------------------------------
    // Shows the last action taken; handy when the pins are hi-Z
    always_comb begin
        case (func_r)
            NBER_CLEAR: begin
                func_nxt = pins.wipe_ok ? NBER_HOLD : NBER_CLEAR;
            end
            NBER_HOLD: begin
                func_nxt = take ? NBER_LOAD : NBER_HOLD;
            end
            NBER_LOAD: begin
                func_nxt = take ? NBER_LOAD : NBER_HOLD;
            end
            default: begin
                func_nxt = NBER_CLEAR;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge clear_rst_n) begin
        if (!clear_rst_n) begin
            func_r <= NBER_CLEAR;
        end else begin
            func_r <= func_nxt;
        end
    end

    assign data_o = store_r;
    assign data_oe_n_o = oe_n_r;
    assign func_o = func_r;

endmodule

// ==== dv/nber_props.sv ====
`timescale 1ns/1ps
`include "nber_regs.svh"

// ----
// Pin-level checks
// ----
module nber_props
    import nber_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic edge_clock_i,
    input wire logic wipe_n_i,
    input wire logic load_n_i,
    input wire logic oe_n_i,
    input wire logic [`NBER_WIDTH-1:0] data_i,
    input wire logic [`NBER_WIDTH-1:0] data_o,
    input wire logic [`NBER_WIDTH-1:0] data_oe_n_o,
    input wire logic [1:0] func_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Six cycles cover the five-edge pin latency
    a_wipe_zero: assert property (!wipe_n_i |-> data_o == '0)
        else $error("clear left data set");
    a_wipe_first: assert property (!wipe_n_i |-> func_o == NBER_CLEAR)
        else $error("clear did not win");
    a_oe_drive: assert property (!oe_n_i [*6] |-> data_oe_n_o == '0)
        else $error("outputs not driven");
    a_oe_float: assert property (oe_n_i [*6] |-> &data_oe_n_o)
        else $error("outputs not released");
    a_gate_hold: assert property ((load_n_i && wipe_n_i) [*6]
        |-> $stable(data_o))
        else $error("held value moved");
    a_load_data: assert property ($rose(func_o == NBER_LOAD)
        |-> data_o == $past(data_i, 3))
        else $error("wrong value loaded");
    a_load_cause: assert property ($rose(func_o == NBER_LOAD)
        |-> $past(edge_clock_i, 3) && !$past(load_n_i, 3)
        && $past(wipe_n_i, 3))
        else $error("load without cause");
    a_change_why: assert property ($changed(data_o)
        |-> func_o != NBER_HOLD)
        else $error("store changed on hold");

    c_load: cover property ($rose(func_o == NBER_LOAD));
    c_load_hiz: cover property (oe_n_i && $rose(func_o == NBER_LOAD));
    c_edge_wipe: cover property (!wipe_n_i && !load_n_i && edge_clock_i);
endmodule

bind nber_top nber_props PROPS (.clk_i, .nrst_i, .edge_clock_i,
    .wipe_n_i, .load_n_i, .oe_n_i, .data_i, .data_o, .data_oe_n_o,
    .func_o);

// ==== dv/nber_far_bus.sv ====
`timescale 1ns/1ps
`include "nber_regs.svh"

// ----
// Far-side bus
// ----
module nber_far_bus (
    input wire logic [`NBER_WIDTH-1:0] drv_i,
    input wire logic [`NBER_WIDTH-1:0] drv_oe_n_i,
    output logic [`NBER_WIDTH-1:0] bus_o
);
    // Released lines float to the pull-up, never hold old data
    always_comb begin
        for (int i = 0; i < `NBER_WIDTH; i++) begin
            bus_o[i] = drv_oe_n_i[i] ? 1'b1 : drv_i[i];
        end
    end
endmodule

// ==== dv/nber_bench.sv ====
`timescale 1ns/1ps
`include "nber_regs.svh"

module nber_bench;
    import nber_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic edge_clock_i = 1'b0;
    logic wipe_n_i = 1'b1;
    logic load_n_i = 1'b1;
    logic oe_n_i = 1'b0;
    logic [8:0] data_i = 9'h000;
    logic [8:0] data_o, data_oe_n_o, bus;
    logic [1:0] func_o;
    logic [8:0] vals [5] = '{9'h1FF, 9'h0AA, 9'h155, 9'h001, 9'h100};
    int n_mismatch = 0;
    int num_checks = 0;

    nber_top DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .edge_clock_i(edge_clock_i), .wipe_n_i(wipe_n_i),
        .load_n_i(load_n_i), .oe_n_i(oe_n_i), .data_i(data_i),
        .data_o(data_o), .data_oe_n_o(data_oe_n_o), .func_o(func_o));
    nber_far_bus FAR (.drv_i(data_o), .drv_oe_n_i(data_oe_n_o),
        .bus_o(bus));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // One device clock pulse; data flips while high to catch late loads
    task automatic pulse(input logic [8:0] d, input logic ld_n);
        data_i = d;
        load_n_i = ld_n;
        cyc(3);
        edge_clock_i = 1'b1;
        cyc(5);
        data_i = ~d;
        cyc(2);
        edge_clock_i = 1'b0;
        cyc(5);
    endtask

    task automatic t_load;
        foreach (vals[i]) begin
            pulse(vals[i], 1'b0);
            chk(data_o, vals[i]);
            chk(bus, vals[i]);
            chk({7'h00, func_o}, 9'h001);
        end
        $display("load done");
    endtask

    task automatic t_hold;
        pulse(9'h0F0, 1'b1);
        chk(data_o, 9'h100);
        $display("hold done");
    endtask

    task automatic t_hiz;
        oe_n_i = 1'b1;
        cyc(6);
        chk(bus, 9'h1FF);
        pulse(9'h0C3, 1'b0);
        chk(data_o, 9'h0C3);
        oe_n_i = 1'b0;
        cyc(6);
        chk(bus, 9'h0C3);
        $display("hiz done");
    endtask

    task automatic t_clear;
        wipe_n_i = 1'b0;
        #1;
        chk(data_o, 9'h000);
        chk({7'h00, func_o}, 9'h000);
        pulse(9'h1E1, 1'b0);
        chk(data_o, 9'h000);
        chk(data_oe_n_o, 9'h000);
        // Release well ahead of the next load edge
        wipe_n_i = 1'b1;
        cyc(6);
        pulse(9'h1E1, 1'b0);
        chk(data_o, 9'h1E1);
        $display("clear done");
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run needs about 3.4 us; a hang is cut well after that
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end

    initial begin
        cyc(12);
        nrst_i = 1'b1;
        cyc(6);
        chk(data_o, 9'h000);
        t_load();
        t_hold();
        t_hiz();
        t_clear();
        final_report();
    end
endmodule
